/* File: asst_seq.sv */
`include "asst_defines.svh"
// Summary of operation
// - stored step level list drives setpoint in order while user step shape selected.
// - each step holds its level for its own dwell before advancing.
// - step with flag set emits one trigger pulse as it begins.
// - step values are tagged with the chosen quantity, fixed at sequence start.
// - at completion restore prior dc setpoint or keep last level, per selection.
// - repeat count sets number of passes; count of one plays once.
// - endless repeat replays list forever until aborted.
// - triggers launch the waveform only in arbitrary transient mode.
// - bus source accepts device trigger command or group execute trigger.
// - immediate source triggers at once on panel or host immediate request.
// - external source accepts any pin configured as trigger input.
// - pin source uses only numbered pin, which must be configured trigger input.
// - host initiates first; forced trigger starts regardless of source.
// - arming delay follows initiation; earlier triggers are discarded.
// - waiting flag at bit 4 of operation status once armed.
module asst_seq import asst_pkg::*; #(
  parameter int ARM_DELAY_CYC = `ASST_ARM_DELAY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // trigger sources outside the register port
  input wire logic bus_get,
  input wire logic panel_imm,
  input wire logic [`ASST_PIN_N-1:0] dig_pin_in,
  // waveform outputs
  output asst_setpt_type setpt,
  output logic trig_out,
  output logic irq
);

  // dwell of zero is treated as one tick so a step always lasts
  function automatic logic [`ASST_DWELL_W-1:0] dwell_ticks(input logic [`ASST_DWELL_W-1:0] d);
    dwell_ticks = (d == '0) ? `ASST_DWELL_W'(1) : d;
  endfunction : dwell_ticks

  // register write decode
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
    wr_hit = w && (a == off);
  endfunction : wr_hit

  // step memories
  logic [`ASST_LEVEL_W-1:0] level_mem [`ASST_STEP_N];
  logic [`ASST_DWELL_W-1:0] dwell_mem [`ASST_STEP_N];
  logic [`ASST_STEP_N-1:0] flag_ff;

  // software registers
  asst_ctrl_type ctrl_ff;
  logic [15:0] rep_cnt_ff;
  logic endless_repeat_ff;
  logic [`ASST_STEP_AW-1:0] last_step_ff;
  logic [`ASST_STEP_AW-1:0] step_sel_ff;
  logic [`ASST_LEVEL_W-1:0] dc_ff;
  logic [`ASST_PIN_N-1:0] pin_cfg_ff;
  logic [`ASST_INT_W-1:0] int_stat_ff;
  logic [`ASST_INT_W-1:0] int_en_ff;
  logic [31:0] rdata_ff;

  // sequencer state
  asst_state_type state_ff;
  asst_state_type nxt_state;
  logic [31:0] arm_cnt_ff;
  logic [6:0] tick_cnt_ff;
  logic tick_ff;
  logic [`ASST_STEP_AW-1:0] idx_ff;
  logic [`ASST_DWELL_W-1:0] dwell_cnt_ff;
  logic [15:0] remain_ff;
  logic [`ASST_LEVEL_W-1:0] saved_dc_ff;
  logic keep_last_run_ff;
  asst_setpt_type setpt_ff;
  logic trig_out_ff;
  logic irq_ff;

  // pin synchronisers and edge detect
  logic [`ASST_PIN_N-1:0] pin_meta_ff;
  logic [`ASST_PIN_N-1:0] pin_sync_ff;
  logic [`ASST_PIN_N-1:0] pin_prev_ff;
  logic [`ASST_PIN_N-1:0] pin_rise;

  // command strobes
  logic cmd_wr;
  logic cmd_init;
  logic cmd_force;
  logic cmd_abort;
  logic bus_trg;
  logic imm_trg;
  logic src_trg;
  logic any_trg;
  logic launch;
  logic step_done;
  logic pass_end;
  logic seq_end;
  logic armed_evt;
  logic discard_evt;
  logic step_evt;
  logic [`ASST_INT_W-1:0] int_set;

  assign cmd_wr = wr_hit(addr, `ASST_REG_CMD, wr);
  assign cmd_init = cmd_wr && wdata[`ASST_CMD_INIT];
  assign cmd_force = cmd_wr && wdata[`ASST_CMD_FORCE];
  assign cmd_abort = cmd_wr && wdata[`ASST_CMD_ABORT];
  assign bus_trg = (cmd_wr && wdata[`ASST_CMD_BUS_TRG]) || bus_get;
  assign imm_trg = (cmd_wr && wdata[`ASST_CMD_IMM]) || panel_imm;
  assign pin_rise = pin_sync_ff & ~pin_prev_ff;

  // trigger source selection
  always_comb begin
    case (ctrl_ff.src)
      ASST_SRC_BUS: src_trg = bus_trg;
      ASST_SRC_IMM: src_trg = imm_trg;
      ASST_SRC_EXT: src_trg = |(pin_rise & pin_cfg_ff);
      ASST_SRC_PIN: src_trg = pin_rise[ctrl_ff.pin_num] & pin_cfg_ff[ctrl_ff.pin_num];
      default: src_trg = 1'b0;
    endcase
  end

  // a forced trigger works whatever the source
  assign any_trg = src_trg || cmd_force;
  // launch needs arm completion and arbitrary mode with the step shape
  assign launch = (state_ff == ASST_WAIT) && any_trg && ctrl_ff.mode_arb
    && ctrl_ff.user_step_shape;
  assign discard_evt = (state_ff == ASST_ARMING) && any_trg;
  assign armed_evt = (state_ff == ASST_ARMING) && (arm_cnt_ff == 32'h0000_0000);
  assign step_done = (state_ff == ASST_RUN) && tick_ff && (dwell_cnt_ff == `ASST_DWELL_W'(1));
  assign pass_end = step_done && (idx_ff == last_step_ff);
  assign seq_end = pass_end && !endless_repeat_ff && (remain_ff <= 16'h0001);
  assign step_evt = trig_out_ff;

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ASST_IDLE: begin
        if (cmd_init) begin
          nxt_state = ASST_ARMING;
        end
      end
      ASST_ARMING: begin
        if (cmd_abort) begin
          nxt_state = ASST_IDLE;
        end else if (armed_evt) begin
          nxt_state = ASST_WAIT;
        end
      end
      ASST_WAIT: begin
        if (cmd_abort) begin
          nxt_state = ASST_IDLE;
        end else if (launch) begin
          nxt_state = ASST_RUN;
        end
      end
      ASST_RUN: begin
        if (cmd_abort || seq_end) begin
          nxt_state = ASST_IDLE;
        end
      end
      default: nxt_state = ASST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ASST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // arming delay counter, loaded on initiation
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_cnt_ff <= 32'h0000_0000;
    end else if (state_ff == ASST_IDLE && cmd_init) begin
      arm_cnt_ff <= 32'(ARM_DELAY_CYC - 1);
    end else if (state_ff == ASST_ARMING && arm_cnt_ff != 32'h0000_0000) begin
      arm_cnt_ff <= arm_cnt_ff - 32'h0000_0001;
    end
  end

  // one microsecond dwell tick, restarted at launch
  always_ff @(posedge clk) begin
    if (rst || launch) begin
      tick_cnt_ff <= 7'h00;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 7'(`ASST_TICK_CYC - 1)) begin
      tick_cnt_ff <= 7'h00;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 7'h01;
      tick_ff <= 1'b0;
    end
  end

  // step index and dwell count
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_ff <= '0;
      dwell_cnt_ff <= '0;
    end else if (launch) begin
      idx_ff <= '0;
      dwell_cnt_ff <= dwell_ticks(dwell_mem[0]);
    end else if (step_done) begin
      if (pass_end) begin
        idx_ff <= '0;
        dwell_cnt_ff <= dwell_ticks(dwell_mem[0]);
      end else begin
        idx_ff <= idx_ff + `ASST_STEP_AW'(1);
        dwell_cnt_ff <= dwell_ticks(dwell_mem[idx_ff + `ASST_STEP_AW'(1)]);
      end
    end else if (state_ff == ASST_RUN && tick_ff) begin
      dwell_cnt_ff <= dwell_cnt_ff - `ASST_DWELL_W'(1);
    end
  end

  // remaining passes; zero is taken as one pass
  always_ff @(posedge clk) begin
    if (rst) begin
      remain_ff <= 16'h0000;
    end else if (launch) begin
      remain_ff <= rep_cnt_ff;
    end else if (pass_end && remain_ff != 16'h0000) begin
      remain_ff <= remain_ff - 16'h0001;
    end
  end

  // snapshot of settings taken as the waveform starts
  always_ff @(posedge clk) begin
    if (rst) begin
      saved_dc_ff <= '0;
      keep_last_run_ff <= 1'b0;
    end else if (launch) begin
      saved_dc_ff <= dc_ff;
      keep_last_run_ff <= ctrl_ff.keep_last;
    end
  end

  // output setpoint
  always_ff @(posedge clk) begin
    if (rst) begin
      setpt_ff <= '0;
    end else if (launch) begin
      setpt_ff.level <= level_mem[0];
      setpt_ff.qty <= ctrl_ff.qty;
    end else if (seq_end || (cmd_abort && state_ff == ASST_RUN)) begin
      if (!keep_last_run_ff || cmd_abort) begin
        setpt_ff.level <= saved_dc_ff;
      end
    end else if (step_done) begin
      setpt_ff.level <= pass_end ? level_mem[0]
        : level_mem[idx_ff + `ASST_STEP_AW'(1)];
    end else if (state_ff != ASST_RUN && wr_hit(addr, `ASST_REG_DC, wr)) begin
      setpt_ff.level <= wdata[`ASST_LEVEL_W-1:0];
      setpt_ff.qty <= ctrl_ff.qty;
    end
  end

  // step start trigger pulse, one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_out_ff <= 1'b0;
    end else if (launch) begin
      trig_out_ff <= flag_ff[0];
    end else if (step_done && !seq_end && !cmd_abort) begin
      trig_out_ff <= pass_end ? flag_ff[0] : flag_ff[idx_ff + `ASST_STEP_AW'(1)];
    end else begin
      trig_out_ff <= 1'b0;
    end
  end

  // digital pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_meta_ff <= dig_pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // control and configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= asst_ctrl_type'(`ASST_CTRL_RST);
      rep_cnt_ff <= 16'h0001;
      endless_repeat_ff <= 1'b0;
      last_step_ff <= '0;
      step_sel_ff <= '0;
      dc_ff <= '0;
      pin_cfg_ff <= '0;
      int_en_ff <= '0;
    end else begin
      if (wr_hit(addr, `ASST_REG_CTRL, wr)) begin
        ctrl_ff <= asst_ctrl_type'(wdata[10:0]);
      end
      if (wr_hit(addr, `ASST_REG_REPEAT, wr)) begin
        rep_cnt_ff <= wdata[15:0];
        endless_repeat_ff <= wdata[16];
      end
      if (wr_hit(addr, `ASST_REG_STEPS, wr)) begin
        last_step_ff <= wdata[`ASST_STEP_AW-1:0];
      end
      if (wr_hit(addr, `ASST_REG_STEP_SEL, wr)) begin
        step_sel_ff <= wdata[`ASST_STEP_AW-1:0];
      end
      if (wr_hit(addr, `ASST_REG_DC, wr)) begin
        dc_ff <= wdata[`ASST_LEVEL_W-1:0];
      end
      if (wr_hit(addr, `ASST_REG_PIN_CFG, wr)) begin
        pin_cfg_ff <= wdata[`ASST_PIN_N-1:0];
      end
      if (wr_hit(addr, `ASST_REG_INT_EN, wr)) begin
        int_en_ff <= wdata[`ASST_INT_W-1:0];
      end
    end
  end

  // step list memories, written at the selected index
  always_ff @(posedge clk) begin
    if (wr_hit(addr, `ASST_REG_LEVEL, wr)) begin
      level_mem[step_sel_ff] <= wdata[`ASST_LEVEL_W-1:0];
    end
    if (wr_hit(addr, `ASST_REG_DWELL, wr)) begin
      dwell_mem[step_sel_ff] <= wdata[`ASST_DWELL_W-1:0];
    end
  end

  // step flags
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_ff <= '0;
    end else if (wr_hit(addr, `ASST_REG_FLAG, wr)) begin
      flag_ff[step_sel_ff] <= wdata[0];
    end
  end

  // sticky interrupt status; a new event wins over a clear
  assign int_set = {discard_evt, armed_evt, seq_end, step_evt};
  always_ff @(posedge clk) begin
    if (rst) begin
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_hit(addr, `ASST_REG_INT_CLR, wr)) begin
        int_stat_ff <= (int_stat_ff & ~wdata[`ASST_INT_W-1:0]) | int_set;
      end else begin
        int_stat_ff <= int_stat_ff | int_set;
      end
      irq_ff <= |(int_stat_ff & int_en_ff);
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      case (addr)
        `ASST_REG_CTRL: rdata_ff <= {21'h000000, ctrl_ff};
        `ASST_REG_REPEAT: rdata_ff <= {15'h0000, endless_repeat_ff, rep_cnt_ff};
        `ASST_REG_STEPS: rdata_ff <= {28'h0000000, last_step_ff};
        `ASST_REG_STEP_SEL: rdata_ff <= {28'h0000000, step_sel_ff};
        `ASST_REG_LEVEL: rdata_ff <= {16'h0000, level_mem[step_sel_ff]};
        `ASST_REG_DWELL: rdata_ff <= {8'h00, dwell_mem[step_sel_ff]};
        `ASST_REG_FLAG: rdata_ff <= {31'h00000000, flag_ff[step_sel_ff]};
        `ASST_REG_DC: rdata_ff <= {16'h0000, dc_ff};
        `ASST_REG_OPSTAT: begin
          rdata_ff <= 32'h0000_0000;
          rdata_ff[`ASST_OP_RUNNING] <= (state_ff == ASST_RUN);
          rdata_ff[`ASST_OP_ARMING] <= (state_ff == ASST_ARMING);
          rdata_ff[`ASST_OP_WAITING] <= (state_ff == ASST_WAIT);
        end
        `ASST_REG_PIN_CFG: rdata_ff <= {24'h000000, pin_cfg_ff};
        `ASST_REG_INT_STAT: rdata_ff <= {28'h0000000, int_stat_ff};
        `ASST_REG_INT_EN: rdata_ff <= {28'h0000000, int_en_ff};
        `ASST_REG_SETPT: rdata_ff <= {14'h0000, setpt_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign rdata = rdata_ff;
  assign setpt = setpt_ff;
  assign trig_out = trig_out_ff;
  assign irq = irq_ff;
endmodule : asst_seq

/* File: asst_defines.svh */
`ifndef ASST_DEFINES_SVH
`define ASST_DEFINES_SVH
// register byte offsets
`define ASST_REG_CTRL 8'h00
`define ASST_REG_REPEAT 8'h04
`define ASST_REG_STEPS 8'h08
`define ASST_REG_STEP_SEL 8'h0c
`define ASST_REG_LEVEL 8'h10
`define ASST_REG_DWELL 8'h14
`define ASST_REG_FLAG 8'h18
`define ASST_REG_DC 8'h1c
`define ASST_REG_CMD 8'h20
`define ASST_REG_OPSTAT 8'h24
`define ASST_REG_PIN_CFG 8'h28
`define ASST_REG_INT_STAT 8'h2c
`define ASST_REG_INT_CLR 8'h30
`define ASST_REG_INT_EN 8'h34
`define ASST_REG_SETPT 8'h38
// command bits
`define ASST_CMD_INIT 0
`define ASST_CMD_FORCE 1
`define ASST_CMD_BUS_TRG 2
`define ASST_CMD_IMM 3
`define ASST_CMD_ABORT 4
// operation status bits
`define ASST_OP_RUNNING 0
`define ASST_OP_ARMING 1
`define ASST_OP_WAITING 4
// interrupt bits
`define ASST_INT_STEP 0
`define ASST_INT_DONE 1
`define ASST_INT_ARMED 2
`define ASST_INT_DISCARD 3
`define ASST_INT_W 4
// sizes and reset values
`define ASST_STEP_AW 4
`define ASST_STEP_N 16
`define ASST_LEVEL_W 16
`define ASST_DWELL_W 24
`define ASST_PIN_N 8
`define ASST_CTRL_RST 11'h000
// timing
`define ASST_CLK_MHZ 100
`define ASST_TICK_NS 1000
`define ASST_CLK_NS 10
`define ASST_TICK_CYC (`ASST_TICK_NS / `ASST_CLK_NS)
`define ASST_ARM_DELAY_US 2000
`define ASST_ARM_DELAY_CYC (`ASST_ARM_DELAY_US * `ASST_CLK_MHZ)
`endif

/* File: asst_pkg.sv */
package asst_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ASST_IDLE = 4'h1,
    ASST_ARMING = 4'h2,
    ASST_WAIT = 4'h4,
    ASST_RUN = 4'h8
  } asst_state_type;
  // trigger source selection
  typedef enum logic [2:0] {
    ASST_SRC_BUS = 3'h0,
    ASST_SRC_IMM = 3'h1,
    ASST_SRC_EXT = 3'h2,
    ASST_SRC_PIN = 3'h3
  } asst_src_type;
  // waveform quantity
  typedef enum logic [1:0] {
    ASST_Q_VOLT = 2'h0,
    ASST_Q_CURR = 2'h1,
    ASST_Q_POW = 2'h2,
    ASST_Q_RES = 2'h3
  } asst_qty_type;
  // control register layout, msb first
  typedef struct packed {
    logic [2:0] pin_num;
    asst_src_type src;
    logic mode_arb;
    logic keep_last;
    asst_qty_type qty;
    logic user_step_shape;
  } asst_ctrl_type;
  // output setpoint carrier
  typedef struct packed {
    asst_qty_type qty;
    logic [15:0] level;
  } asst_setpt_type;
endpackage : asst_pkg

/* File: asst_seq_asserts.sv */
module asst_seq_asserts import asst_pkg::*; #(
  parameter int ARM_DELAY_CYC = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // waveform outputs
  input wire asst_setpt_type setpt,
  input wire logic trig_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // read data only stands in the cycle after a read
  property p_rdata_quiet;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read answer");

  // write-only and unmapped places read as zero
  property p_refused_read;
    rd && (addr == 8'h20 || addr == 8'h30 || addr > 8'h38 || addr[1:0] != 2'h0) |=> rdata == 32'h0;
  endproperty
  a_refused_read: assert property (p_refused_read) else $error("refused read gave data");

  // waiting flag never shown beside running or arming
  property p_status_excl;
    rd && addr == 8'h24 |=> !(rdata[4] && (rdata[0] || rdata[1]));
  endproperty
  a_status_excl: assert property (p_status_excl) else $error("waiting flag with busy state");

  // step start pulse lasts one cycle
  property p_pulse_single;
    trig_out |=> !trig_out;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("trigger pulse too long");

  // abort keeps step pulses off for eight cycles from two cycles on
  property p_abort_quiet;
    wr && addr == 8'h20 && wdata[4] |=> ##1 !trig_out [*8];
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("pulse after abort");

  // a step level holds for eight cycles after it changes unless the host writes
  property p_setpt_hold;
    $changed(setpt) && !$past(wr) |=> ($stable(setpt) || $past(wr)) [*8];
  endproperty
  a_setpt_hold: assert property (p_setpt_hold) else $error("setpoint left step early");

  // clearing every enable drops the interrupt two cycles on
  property p_irq_masked;
    wr && addr == 8'h34 && wdata[3:0] == 4'h0 |=> ##1 !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt high while masked");

  // step count reads back what was written
  property p_steps_back;
    wr && addr == 8'h08 ##2 rd && addr == 8'h08 |=> rdata[3:0] == $past(wdata[3:0], 3);
  endproperty
  a_steps_back: assert property (p_steps_back) else $error("step count readback wrong");
endmodule : asst_seq_asserts

bind asst_seq asst_seq_asserts #(.ARM_DELAY_CYC(ARM_DELAY_CYC)) i_asserts (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .setpt(setpt), .trig_out(trig_out), .irq(irq));

/* File: asst_pins.sv */
module asst_pins (
  // clock
  input wire logic clk,
  // pulse request
  input wire logic fire,
  input wire logic [2:0] pin_sel,
  // digital port pins
  output logic [7:0] dig_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_cnt = 2'h0;
  initial dig_pin_in = 8'h00;
  // raise the chosen pin long enough for the synchroniser, then release
  always @(posedge clk) begin
    if (fire) begin
      dig_pin_in <= 8'h01 << pin_sel;
      hold_cnt <= 2'h3;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end else begin
      dig_pin_in <= 8'h00;
    end
  end
endmodule : asst_pins

/* File: asst_seq_tb.sv */
`include "asst_defines.svh"
module asst_seq_tb import asst_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ARM = 20;
  typedef struct {
    asst_src_type src;
    logic [2:0] pnum;
    logic mode;
    int kind;
    logic [2:0] pin;
    logic hit;
  } asst_row_type;
  // source setup, trigger kind and pin, launch expected
  asst_row_type rows [0:10] = '{
    '{ASST_SRC_BUS, 3'h0, 1'b1, 1, 3'h0, 1'b0}, '{ASST_SRC_BUS, 3'h0, 1'b1, 5, 3'h0, 1'b1},
    '{ASST_SRC_IMM, 3'h0, 1'b1, 0, 3'h0, 1'b0}, '{ASST_SRC_IMM, 3'h0, 1'b1, 1, 3'h0, 1'b1},
    '{ASST_SRC_IMM, 3'h0, 1'b1, 2, 3'h0, 1'b1}, '{ASST_SRC_EXT, 3'h0, 1'b1, 3, 3'h0, 1'b0},
    '{ASST_SRC_EXT, 3'h0, 1'b1, 3, 3'h2, 1'b1}, '{ASST_SRC_PIN, 3'h5, 1'b1, 3, 3'h2, 1'b0},
    '{ASST_SRC_PIN, 3'h5, 1'b0, 4, 3'h0, 1'b0}, '{ASST_SRC_PIN, 3'h5, 1'b1, 4, 3'h0, 1'b1},
    '{ASST_SRC_PIN, 3'h5, 1'b1, 3, 3'h5, 1'b1}};
  logic [7:0] ra [0:6] = '{8'h00, 8'h04, 8'h08, 8'h28, 8'h20, 8'h3c, 8'h01};
  logic [31:0] rv [0:6] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [15:0] lv [0:2] = '{16'h0101, 16'h0202, 16'h0303};
  int dw [0:2] = '{1, 2, 1};
  logic fl [0:2] = '{1'b0, 1'b0, 1'b1};
  logic clk;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bus_get = 1'b0;
  logic panel_imm = 1'b0;
  logic fire = 1'b0;
  logic [2:0] pin_sel = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] d;
  logic [31:0] rdata;
  logic [7:0] dig_pin_in;
  asst_setpt_type setpt;
  logic trig_out;
  logic irq;
  asst_ctrl_type c;
  int num_errors = 0;
  int checked = 0;

  asst_seq #(.ARM_DELAY_CYC(ARM)) i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .bus_get(bus_get), .panel_imm(panel_imm),
    .dig_pin_in(dig_pin_in), .setpt(setpt), .trig_out(trig_out), .irq(irq));
  asst_pins i_pins (.clk(clk), .fire(fire), .pin_sel(pin_sel), .dig_pin_in(dig_pin_in));

  // compare and count
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // register port cycles
  task automatic wr_reg(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // abort, configure, initiate
  task automatic arm(asst_src_type s, logic [2:0] pn, logic m, logic k, asst_qty_type q,
                     logic [16:0] rep);
    wr_reg(`ASST_REG_CMD, 32'h10);
    c = '{pin_num: pn, src: s, mode_arb: m, keep_last: k, qty: q, user_step_shape: 1'b1};
    wr_reg(`ASST_REG_CTRL, {21'h0, c});
    wr_reg(`ASST_REG_REPEAT, {15'h0, rep});
    wr_reg(`ASST_REG_CMD, 32'h1);
  endtask : arm
  task automatic wait_armed();
    d = 32'h0;
    for (int i = 0; i < 40 && d[4] !== 1'b1; i++) rd_reg(`ASST_REG_OPSTAT);
    chk("armed", {31'h0, d[4]}, 32'h1);
  endtask : wait_armed
  // apply one trigger of the given kind
  task automatic fire_trig(int k, logic [2:0] p);
    case (k)
      0, 1: begin
        @(posedge clk);
        if (k == 0) bus_get <= 1'b1;
        else panel_imm <= 1'b1;
        @(posedge clk);
        bus_get <= 1'b0;
        panel_imm <= 1'b0;
      end
      2: wr_reg(`ASST_REG_CMD, 32'h8);
      3: begin
        @(posedge clk);
        pin_sel <= p;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
      end
      4: wr_reg(`ASST_REG_CMD, 32'h2);
      default: wr_reg(`ASST_REG_CMD, 32'h4);
    endcase
  endtask : fire_trig
  // check one step from its first cycle to its last
  task automatic hold_step(logic [15:0] l, logic f, int n, asst_qty_type q);
    chk("step level", {14'h0, setpt}, {14'h0, q, l});
    chk("step pulse", {31'h0, trig_out}, {31'h0, f});
    repeat (n * 100 - 1) @(posedge clk);
    #1 chk("step held", {16'h0, setpt.level}, {16'h0, l});
    @(posedge clk);
    #1;
  endtask : hold_step
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (10000) @(posedge clk);
    num_errors++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      chk("reset read", d, rv[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      wr_reg(`ASST_REG_STEP_SEL, i);
      wr_reg(`ASST_REG_LEVEL, {16'h0, lv[i]});
      wr_reg(`ASST_REG_DWELL, dw[i]);
      wr_reg(`ASST_REG_FLAG, {31'h0, fl[i]});
    end
    wr_reg(`ASST_REG_STEPS, 32'h2);
    rd_reg(`ASST_REG_STEPS);
    chk("steps", d, 32'h2);
    wr_reg(`ASST_REG_DC, 32'h0aaa);
    wr_reg(`ASST_REG_INT_EN, 32'hf);
    wr_reg(`ASST_REG_PIN_CFG, 32'h24);
    arm(ASST_SRC_BUS, 3'h0, 1'b1, 1'b0, ASST_Q_POW, 17'h2);
    fire_trig(0, 3'h0);
    wait_armed();
    rd_reg(`ASST_REG_INT_STAT);
    chk("early trigger", {28'h0, d[3:0]}, 32'hc);
    fire_trig(0, 3'h0);
    for (int i = 0; i < 8 && setpt.level !== lv[0]; i++) begin
      @(posedge clk);
      #1;
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 3; i++) hold_step(lv[i], fl[i], dw[i], ASST_Q_POW);
    end
    chk("end level", {16'h0, setpt.level}, 32'h0aaa);
    repeat (2) @(posedge clk);
    #1 chk("irq set", {31'h0, irq}, 32'h1);
    rd_reg(`ASST_REG_INT_STAT);
    chk("int status", d, 32'hf);
    wr_reg(`ASST_REG_INT_EN, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", {31'h0, irq}, 32'h0);
    wr_reg(`ASST_REG_INT_CLR, 32'hf);
    wr_reg(`ASST_REG_INT_EN, 32'hf);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test sequence done");
    wr_reg(`ASST_REG_STEPS, 32'h0);
    arm(ASST_SRC_IMM, 3'h0, 1'b1, 1'b0, ASST_Q_VOLT, 17'h10001);
    wait_armed();
    fire_trig(1, 3'h0);
    repeat (450) @(posedge clk);
    rd_reg(`ASST_REG_OPSTAT);
    chk("endless running", {31'h0, d[0]}, 32'h1);
    wr_reg(`ASST_REG_CMD, 32'h10);
    rd_reg(`ASST_REG_OPSTAT);
    chk("aborted", {27'h0, d[4:0]}, 32'h0);
    chk("abort level", {16'h0, setpt.level}, 32'h0aaa);
    $display("test endless done");
    foreach (rows[i]) begin
      arm(rows[i].src, rows[i].pnum, rows[i].mode, 1'b1, ASST_Q_VOLT, 17'h1);
      wait_armed();
      fire_trig(rows[i].kind, rows[i].pin);
      repeat (6) @(posedge clk);
      #1;
      chk("launch", {31'h0, setpt.level === lv[0]}, {31'h0, rows[i].hit});
    end
    repeat (110) @(posedge clk);
    #1 chk("kept level", {16'h0, setpt.level}, {16'h0, lv[0]});
    rd_reg(`ASST_REG_OPSTAT);
    chk("disarmed", {27'h0, d[4:0]}, 32'h0);
    $display("test trigger sources done");
    conclude();
  end
endmodule : asst_seq_tb
